/* File: src/uifc_pkg.sv */
// Purpose: Shared constants and carriers for the USB interface manager register bank
// Assumes: One 32-bit register word per offset, byte addresses as printed
// Notes: UTMI+ signal groups travel as packed structs
package uifc_pkg;
	localparam logic [7:0] PERIPH_NUM = 8'h01;
	localparam logic [7:0] OFS_RESET = 8'h00;
	localparam logic [7:0] OFS_CONTROL = 8'h04;
	localparam logic [7:0] OFS_DEV_ADDR = 8'h08;
	localparam logic [7:0] OFS_FUNC = 8'h0C;
	localparam logic [7:0] OFS_OTG_CTRL = 8'h10;
	localparam logic [7:0] OFS_OTG_STAT = 8'h14;
	localparam logic [7:0] OFS_SERIAL = 8'h18;
	localparam logic [7:0] OFS_FLAGS = 8'h1C;
	localparam logic [7:0] OFS_HOLD = 8'h20;
	localparam logic [7:0] OFS_PMASK = 8'h24;
	localparam logic [7:0] OFS_SOF = 8'h28;
	localparam logic [7:0] OFS_PID = 8'h2C;
	localparam logic [7:0] OFS_ENDP = 8'h30;
	localparam logic [7:0] OFS_EP_SPECIAL = 8'h34;
	localparam logic [7:0] OFS_OTG_MASK = 8'h38;
	localparam logic [7:0] OFS_PWRSIG = 8'h3C;
	localparam logic [7:0] OFS_PHY_CTRL = 8'h40;
	// Control register bits
	localparam int CTL_TOKEN_PROC = 0;
	localparam int CTL_TOKEN_CHECK = 1;
	localparam int CTL_LINE_DEC = 2;
	localparam int CTL_IF_TIMING = 4;
	localparam int CTL_PWRSIG = 5;
	localparam int CTL_SOF_TOKEN = 6;
	localparam int CTL_XEV_ACK = 7;
	localparam logic [7:0] CTL_WMASK = 8'hF7;
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [6:0] DEV_ADDR_RESET = 7'h00;
	// Functional control
	localparam int FUNC_XCVR = 0;
	localparam int FUNC_TERM = 1;
	localparam int FUNC_OPMODE_LO = 2;
	localparam logic [2:0] OPMODE_RESET = 3'h1;
	localparam logic TERM_RESET = 1'b1;
	localparam logic XCVR_RESET = 1'b1;
	// On-the-go control
	localparam int OTG_ID_PULLUP = 0;
	localparam int OTG_DP_PULLDOWN = 1;
	localparam int OTG_DM_PULLDOWN = 2;
	localparam int OTG_DISCHRG = 3;
	localparam int OTG_CHRG = 4;
	localparam int OTG_DRV_EXT = 6;
	localparam int OTG_EXT_IND = 7;
	localparam logic [7:0] OTG_WMASK = 8'hDF;
	localparam logic [7:0] OTG_RESET = 8'h00;
	// Serial control
	localparam int SER_FSLS = 0;
	localparam int SER_TXEN_LOW = 1;
	localparam int SER_TXDAT = 2;
	localparam int SER_TXSE0 = 3;
	localparam int SER_RXDP = 4;
	localparam int SER_RXDM = 5;
	localparam int SER_RXRCV = 6;
	localparam logic [3:0] SER_RESET = 4'h2;
	// Signal flags
	localparam int FLG_RXERROR = 0;
	localparam int FLG_RXACTIVE = 1;
	localparam int FLG_CRC16 = 2;
	localparam int FLG_J = 3;
	localparam int FLG_K = 4;
	localparam int FLG_SE0 = 5;
	localparam int FLG_NEW_TOKEN = 6;
	localparam int NUM_FLAGS = 7;
	localparam logic [6:0] FLAGS_RESET = 7'h00;
	localparam logic [1:0] LS_SE0 = 2'h0;
	localparam logic [1:0] LS_J = 2'h1;
	localparam logic [1:0] LS_K = 2'h2;
	localparam logic [3:0] PID_SOF = 4'h5;
	localparam logic [4:0] EP_SPECIAL_TAG = 5'h10;
	localparam int NUM_PORTS = 4;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
	// Reset values of captured and plain storage words
	localparam logic [3:0] PID_RESET = 4'h0;
	localparam logic [4:0] ENDP_RESET = 5'h00;
	localparam logic [10:0] SOF_RESET = 11'h000;
	localparam logic [6:0] HOLD_RESET = 7'h00;
	localparam logic [31:0] PMASK_RESET = 32'h0000_0000;
	localparam logic [15:0] EP_SPECIAL_RESET = 16'h0000;
	localparam logic [31:0] OTG_MASK_RESET = 32'h0000_0000;
	localparam logic [8:0] PWRSIG_RESET = 9'h000;
	localparam logic [18:0] PHY_CTRL_RESET = 19'h00000;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] periph;
		logic [7:0] addr;
		logic is_32bit;
		logic [31:0] wdata;
	} uifc_req_s;

	typedef struct packed {
		logic valid;
		logic error;
		logic [31:0] rdata;
	} uifc_resp_s;

	typedef struct packed {
		logic [2:0] opmode;
		logic termselect;
		logic xcvrselect;
		logic chrgvbus;
		logic dischrgvbus;
		logic dmpulldown;
		logic dppulldown;
		logic identification_pullup;
		logic drive_bus_power_external;
		logic external_bus_power_indicator;
		logic txse0;
		logic txdat;
		logic transmit_enable_low;
		logic full_low_speed_serial_select;
	} uifc_utmi_ctrl_s;

	typedef struct packed {
		logic sessend;
		logic sessvld;
		logic vbusvld;
		logic hostdis;
		logic idgnd;
		logic sessvld_b;
		logic rxrcv;
		logic rxdm;
		logic rxdp;
		logic rxactive;
		logic rxerror;
		logic [1:0] linestate;
		logic crc16_fail;
	} uifc_utmi_stat_s;

	typedef struct packed {
		logic valid;
		logic [3:0] pid;
		logic pid_ok;
		logic crc5_ok;
		logic [6:0] addr;
		logic [3:0] endp;
	} uifc_token_s;
endpackage

/* File: src/uifc_regs.sv */
// Purpose: Register bank of the USB interface manager, reached as peripheral 1
// Assumes: Requests last one cycle; answer follows one cycle later
// Notes: A write to the reset word restores all bank state, not the transceiver

// Function
// - Only peripheral 1 and 32-bit accesses are accepted; narrow ones are refused, other peripherals get no answer.
// - Any 32-bit write to offset zero returns all bank state to initial values.
// - Control bit 0 enables token processing, bit 1 token checking.
// - Control bit 2 enables line-state decoding; bit 3 reads zero.
// - Control bit 4 enables interface timing, bit 5 power signalling.
// - Control bits 6 and 7 are mode enables; bits 31:8 read zero.
// - Seven-bit device address; only tokens to that address pass on.
// - Functional bits 4:2 drive operating mode, reset value 1.
// - Functional bit 1 drives termination select, bit 0 transceiver select.
// - OTG bits 4..1 drive bus charge, discharge, minus and plus pulldowns.
// - OTG bit 0 id pull-up, bit 6 external drive, bit 7 indicator.
// - OTG status word shows live transceiver session and id flags.
// - Serial bits 6..4 report differential, minus and plus receive lines.
// - Serial bit 3 drives single-ended-zero transmit, bit 2 transmit data.
// - Serial bit 1 is active-low transmit enable, reset to one.
// - Serial bit 0 selects full/low-speed serial mode; upper bits zero.
// - New-token flag sets only on good check, good identifier, matching address.
module uifc_regs (
	input wire logic clk,
	input wire logic rst,
	input wire uifc_pkg::uifc_req_s req,
	output uifc_pkg::uifc_resp_s resp,
	input wire uifc_pkg::uifc_utmi_stat_s utmi_stat,
	output uifc_pkg::uifc_utmi_ctrl_s utmi_ctrl,
	input wire uifc_pkg::uifc_token_s token,
	output logic token_pass,
	output logic [4:0] token_endpoint,
	output logic [3:0] port_flag,
	output logic [7:0] mode_enables
);
	logic [7:0] ctl_reg;
	logic [6:0] dev_addr_reg;
	logic [4:0] func_reg;
	logic [7:0] otg_reg;
	logic [3:0] ser_reg;
	logic [6:0] flags_reg;
	logic [6:0] flags_next;
	logic [6:0] hold_reg;
	logic [31:0] pmask_reg;
	logic [10:0] sof_reg;
	logic [3:0] pid_reg;
	logic [4:0] endp_reg;
	logic [15:0] ep_special_reg;
	logic [31:0] otg_mask_reg;
	logic [8:0] pwrsig_reg;
	logic [18:0] phy_ctrl_reg;
	logic rxactive_d_reg;
	logic accept;
	logic soft_rst;
	logic clr_all;
	logic token_good;
	logic [6:0] events;
	logic [6:0] flag_clear;
	logic packet_start;
	logic [31:0] rd_word;
	logic rd_hit;

	function automatic logic wr_to(input uifc_pkg::uifc_req_s r, input logic [7:0] ofs);
		wr_to = r.valid && r.write && r.periph == uifc_pkg::PERIPH_NUM && r.is_32bit
			&& r.addr == ofs;
	endfunction

	assign accept = req.valid && req.periph == uifc_pkg::PERIPH_NUM && req.is_32bit;
	assign soft_rst = wr_to(req, uifc_pkg::OFS_RESET);
	assign clr_all = rst || soft_rst;

	// Control word
	always_ff @(posedge clk) begin
		if (clr_all) begin
			ctl_reg <= uifc_pkg::CTL_RESET;
		end else if (wr_to(req, uifc_pkg::OFS_CONTROL)) begin
			ctl_reg <= req.wdata[7:0] & uifc_pkg::CTL_WMASK;
		end
	end
	assign mode_enables = ctl_reg;

	// Device address
	always_ff @(posedge clk) begin
		if (clr_all) begin
			dev_addr_reg <= uifc_pkg::DEV_ADDR_RESET;
		end else if (wr_to(req, uifc_pkg::OFS_DEV_ADDR)) begin
			dev_addr_reg <= req.wdata[6:0];
		end
	end

	// Functional control
	always_ff @(posedge clk) begin
		if (clr_all) begin
			func_reg <= {uifc_pkg::OPMODE_RESET, uifc_pkg::TERM_RESET, uifc_pkg::XCVR_RESET};
		end else if (wr_to(req, uifc_pkg::OFS_FUNC)) begin
			func_reg <= req.wdata[4:0];
		end
	end

	// On-the-go control
	always_ff @(posedge clk) begin
		if (clr_all) begin
			otg_reg <= uifc_pkg::OTG_RESET;
		end else if (wr_to(req, uifc_pkg::OFS_OTG_CTRL)) begin
			otg_reg <= req.wdata[7:0] & uifc_pkg::OTG_WMASK;
		end
	end

	// Serial control writable part
	always_ff @(posedge clk) begin
		if (clr_all) begin
			ser_reg <= uifc_pkg::SER_RESET;
		end else if (wr_to(req, uifc_pkg::OFS_SERIAL)) begin
			ser_reg <= req.wdata[3:0];
		end
	end

	// Transceiver control outputs
	always_comb begin
		utmi_ctrl.opmode = func_reg[uifc_pkg::FUNC_OPMODE_LO +: 3];
		utmi_ctrl.termselect = func_reg[uifc_pkg::FUNC_TERM];
		utmi_ctrl.xcvrselect = func_reg[uifc_pkg::FUNC_XCVR];
		utmi_ctrl.chrgvbus = otg_reg[uifc_pkg::OTG_CHRG];
		utmi_ctrl.dischrgvbus = otg_reg[uifc_pkg::OTG_DISCHRG];
		utmi_ctrl.dmpulldown = otg_reg[uifc_pkg::OTG_DM_PULLDOWN];
		utmi_ctrl.dppulldown = otg_reg[uifc_pkg::OTG_DP_PULLDOWN];
		utmi_ctrl.identification_pullup = otg_reg[uifc_pkg::OTG_ID_PULLUP];
		utmi_ctrl.drive_bus_power_external = otg_reg[uifc_pkg::OTG_DRV_EXT];
		utmi_ctrl.external_bus_power_indicator = otg_reg[uifc_pkg::OTG_EXT_IND];
		utmi_ctrl.txse0 = ser_reg[uifc_pkg::SER_TXSE0];
		utmi_ctrl.txdat = ser_reg[uifc_pkg::SER_TXDAT];
		utmi_ctrl.transmit_enable_low = ser_reg[uifc_pkg::SER_TXEN_LOW];
		utmi_ctrl.full_low_speed_serial_select = ser_reg[uifc_pkg::SER_FSLS];
	end

	// Token filter
	assign token_good = token.valid && ctl_reg[uifc_pkg::CTL_TOKEN_PROC]
		&& token.crc5_ok && token.pid_ok && token.addr == dev_addr_reg;

	always_ff @(posedge clk) begin
		if (clr_all) begin
			token_pass <= 1'b0;
			token_endpoint <= uifc_pkg::ENDP_RESET;
		end else begin
			token_pass <= token_good;
			if (token_good) begin
				token_endpoint <= ep_special_reg[token.endp] ?
					({1'b0, token.endp} | uifc_pkg::EP_SPECIAL_TAG) : {1'b0, token.endp};
			end
		end
	end

	// Last identifier, endpoint and frame number
	always_ff @(posedge clk) begin
		if (clr_all) begin
			pid_reg <= uifc_pkg::PID_RESET;
			endp_reg <= uifc_pkg::ENDP_RESET;
		end else if (token.valid && ctl_reg[uifc_pkg::CTL_TOKEN_PROC]) begin
			pid_reg <= token.pid;
			if (token_good) begin
				endp_reg <= {1'b1, token.endp};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (clr_all) begin
			sof_reg <= uifc_pkg::SOF_RESET;
		end else if (token.valid && token.pid == uifc_pkg::PID_SOF && token.crc5_ok) begin
			sof_reg <= {token.endp, token.addr};
		end else if (wr_to(req, uifc_pkg::OFS_SOF)) begin
			sof_reg <= req.wdata[10:0];
		end
	end

	// Signal flags
	always_ff @(posedge clk) begin
		if (clr_all) begin
			rxactive_d_reg <= 1'b0;
		end else begin
			rxactive_d_reg <= utmi_stat.rxactive;
		end
	end
	assign packet_start = utmi_stat.rxactive && !rxactive_d_reg;

	always_comb begin
		events = 7'h00;
		events[uifc_pkg::FLG_RXERROR] = utmi_stat.rxerror;
		events[uifc_pkg::FLG_RXACTIVE] = utmi_stat.rxactive;
		events[uifc_pkg::FLG_CRC16] = utmi_stat.crc16_fail;
		if (ctl_reg[uifc_pkg::CTL_LINE_DEC]) begin
			events[uifc_pkg::FLG_J] = utmi_stat.linestate == uifc_pkg::LS_J;
			events[uifc_pkg::FLG_K] = utmi_stat.linestate == uifc_pkg::LS_K;
			events[uifc_pkg::FLG_SE0] = utmi_stat.linestate == uifc_pkg::LS_SE0;
		end
		events[uifc_pkg::FLG_NEW_TOKEN] = token_good;
		flag_clear = wr_to(req, uifc_pkg::OFS_FLAGS) ? req.wdata[6:0] : 7'h00;
	end

	genvar gi;
	generate
		for (gi = 0; gi < uifc_pkg::NUM_FLAGS; gi++) begin : g_flag
			always_comb begin
				if (hold_reg[gi]) begin
					flags_next[gi] = events[gi] || (flags_reg[gi] && !flag_clear[gi]);
				end else if (gi <= uifc_pkg::FLG_RXACTIVE) begin
					flags_next[gi] = events[gi];
				end else begin
					flags_next[gi] = events[gi]
						|| (flags_reg[gi] && !flag_clear[gi] && !packet_start);
				end
			end
		end
		for (gi = 0; gi < uifc_pkg::NUM_PORTS; gi++) begin : g_port
			always_ff @(posedge clk) begin
				if (clr_all) begin
					port_flag[gi] <= 1'b0;
				end else begin
					port_flag[gi] <= |(flags_next & pmask_reg[gi*8 +: 7]);
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (clr_all) begin
			flags_reg <= uifc_pkg::FLAGS_RESET;
		end else begin
			flags_reg <= flags_next;
		end
	end

	// Flag hold select
	always_ff @(posedge clk) begin
		if (clr_all) begin
			hold_reg <= uifc_pkg::HOLD_RESET;
		end else if (wr_to(req, uifc_pkg::OFS_HOLD)) begin
			hold_reg <= req.wdata[6:0];
		end
	end

	// Flag port masks
	always_ff @(posedge clk) begin
		if (clr_all) begin
			pmask_reg <= uifc_pkg::PMASK_RESET;
		end else if (wr_to(req, uifc_pkg::OFS_PMASK)) begin
			pmask_reg <= req.wdata;
		end
	end

	// Special endpoint select
	always_ff @(posedge clk) begin
		if (clr_all) begin
			ep_special_reg <= uifc_pkg::EP_SPECIAL_RESET;
		end else if (wr_to(req, uifc_pkg::OFS_EP_SPECIAL)) begin
			ep_special_reg <= req.wdata[15:0];
		end
	end

	// On-the-go status mask
	always_ff @(posedge clk) begin
		if (clr_all) begin
			otg_mask_reg <= uifc_pkg::OTG_MASK_RESET;
		end else if (wr_to(req, uifc_pkg::OFS_OTG_MASK)) begin
			otg_mask_reg <= req.wdata;
		end
	end

	// Power signalling word
	always_ff @(posedge clk) begin
		if (clr_all) begin
			pwrsig_reg <= uifc_pkg::PWRSIG_RESET;
		end else if (wr_to(req, uifc_pkg::OFS_PWRSIG)) begin
			pwrsig_reg <= req.wdata[8:0];
		end
	end

	// Transceiver control word
	always_ff @(posedge clk) begin
		if (clr_all) begin
			phy_ctrl_reg <= uifc_pkg::PHY_CTRL_RESET;
		end else if (wr_to(req, uifc_pkg::OFS_PHY_CTRL)) begin
			phy_ctrl_reg <= req.wdata[18:0];
		end
	end

	// Read decode
	always_comb begin
		rd_word = uifc_pkg::ZERO_WORD;
		rd_hit = 1'b1;
		case (req.addr)
			uifc_pkg::OFS_RESET: rd_word = uifc_pkg::ZERO_WORD;
			uifc_pkg::OFS_CONTROL: rd_word = {24'h000000, ctl_reg};
			uifc_pkg::OFS_DEV_ADDR: rd_word = {25'h0000000, dev_addr_reg};
			uifc_pkg::OFS_FUNC: rd_word = {27'h0000000, func_reg};
			uifc_pkg::OFS_OTG_CTRL: rd_word = {24'h000000, otg_reg};
			uifc_pkg::OFS_OTG_STAT: begin
				rd_word = {26'h0000000, utmi_stat.sessvld_b, utmi_stat.idgnd,
					utmi_stat.hostdis, utmi_stat.vbusvld, utmi_stat.sessvld,
					utmi_stat.sessend};
			end
			uifc_pkg::OFS_SERIAL: begin
				rd_word = {25'h0000000, utmi_stat.rxrcv, utmi_stat.rxdm, utmi_stat.rxdp,
					ser_reg};
			end
			uifc_pkg::OFS_FLAGS: rd_word = {25'h0000000, flags_reg};
			uifc_pkg::OFS_HOLD: rd_word = {25'h0000000, hold_reg};
			uifc_pkg::OFS_PMASK: rd_word = pmask_reg;
			uifc_pkg::OFS_SOF: rd_word = {21'h000000, sof_reg};
			uifc_pkg::OFS_PID: rd_word = {28'h0000000, pid_reg};
			uifc_pkg::OFS_ENDP: rd_word = {27'h0000000, endp_reg};
			uifc_pkg::OFS_EP_SPECIAL: rd_word = {16'h0000, ep_special_reg};
			uifc_pkg::OFS_OTG_MASK: rd_word = otg_mask_reg;
			uifc_pkg::OFS_PWRSIG: rd_word = {23'h000000, pwrsig_reg};
			uifc_pkg::OFS_PHY_CTRL: rd_word = {13'h0000, phy_ctrl_reg};
			default: rd_hit = 1'b0;
		endcase
	end

	// Answer one cycle after the request
	always_ff @(posedge clk) begin
		if (rst) begin
			resp <= '0;
		end else begin
			resp.valid <= req.valid && req.periph == uifc_pkg::PERIPH_NUM;
			resp.error <= req.valid && req.periph == uifc_pkg::PERIPH_NUM
				&& (!req.is_32bit || !rd_hit);
			resp.rdata <= (accept && !req.write && rd_hit) ? rd_word : uifc_pkg::ZERO_WORD;
		end
	end
endmodule

/* File: verification/uifc_regs_props.sv */
// Purpose: Port assertions for the interface manager register bank
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to every uifc_regs instance
module uifc_regs_props (
	input wire logic clk,
	input wire logic rst,
	input wire uifc_pkg::uifc_req_s req,
	input wire uifc_pkg::uifc_resp_s resp,
	input wire uifc_pkg::uifc_utmi_stat_s utmi_stat,
	input wire uifc_pkg::uifc_utmi_ctrl_s utmi_ctrl,
	input wire uifc_pkg::uifc_token_s token,
	input wire logic token_pass,
	input wire logic [4:0] token_endpoint,
	input wire logic [3:0] port_flag,
	input wire logic [7:0] mode_enables
);
	timeunit 1ns;
	timeprecision 1ps;
	wire logic ours = req.valid && req.periph == 8'h01;
	wire logic good_wr = ours && req.is_32bit && req.write;
	wire logic good_rd = ours && req.is_32bit && !req.write;
	logic [31:0] wd_q;
	uifc_pkg::uifc_utmi_stat_s st_q;
	// Request word and status one cycle back
	always_ff @(posedge clk) begin
		wd_q <= req.wdata;
		st_q <= utmi_stat;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_answer_next: assert property (ours |=> resp.valid)
		else $error("no answer to own request");
	a_foreign_silent: assert property (req.valid && req.periph != 8'h01 |=> !resp.valid)
		else $error("answer to foreign peripheral");
	a_narrow_error: assert property (ours && !req.is_32bit |=> resp.error)
		else $error("narrow access not refused");
	a_soft_reset: assert property (good_wr && req.addr == 8'h00 |=> mode_enables == 8'h00
		&& utmi_ctrl.opmode == 3'h1 && utmi_ctrl.termselect && utmi_ctrl.transmit_enable_low)
		else $error("soft reset left state");
	a_ctl_write: assert property (good_wr && req.addr == 8'h04 |=> mode_enables == (wd_q[7:0] & 8'hF7))
		else $error("control write mismatch");
	a_ctl_hold: assert property (!(good_wr && req.addr inside {8'h00, 8'h04}) |=> $stable(mode_enables))
		else $error("control changed unasked");
	a_func_drive: assert property (good_wr && req.addr == 8'h0C
		|=> {utmi_ctrl.opmode, utmi_ctrl.termselect, utmi_ctrl.xcvrselect} == wd_q[4:0])
		else $error("functional outputs mismatch");
	a_serial_drive: assert property (good_wr && req.addr == 8'h18 |=> {utmi_ctrl.txse0,
		utmi_ctrl.txdat, utmi_ctrl.transmit_enable_low, utmi_ctrl.full_low_speed_serial_select} == wd_q[3:0])
		else $error("serial outputs mismatch");
	a_otg_status: assert property (good_rd && req.addr == 8'h14 |=> resp.rdata == {26'h0,
		st_q.sessvld_b, st_q.idgnd, st_q.hostdis, st_q.vbusvld, st_q.sessvld, st_q.sessend})
		else $error("status word mismatch");
	a_reset_reads_zero: assert property (good_rd && req.addr == 8'h00 |=> resp.rdata == 32'h0)
		else $error("reset word read not zero");
	a_bad_token: assert property (token.valid && !(token.crc5_ok && token.pid_ok) |=> !token_pass)
		else $error("bad token passed");
endmodule
bind uifc_regs uifc_regs_props u_props (.clk(clk), .rst(rst), .req(req), .resp(resp),
	.utmi_stat(utmi_stat), .utmi_ctrl(utmi_ctrl), .token(token), .token_pass(token_pass),
	.token_endpoint(token_endpoint), .port_flag(port_flag), .mode_enables(mode_enables));

/* File: verification/uifc_phy_model.sv */
// Purpose: Transceiver side model giving status levels and decoded tokens
// Assumes: Changes only at the falling edge of clk
// Notes: Token fields are zero before the first token and carry inverted junk between tokens
module uifc_phy_model (
	input wire logic clk,
	output uifc_pkg::uifc_utmi_stat_s utmi_stat,
	output uifc_pkg::uifc_token_s token
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		utmi_stat = '0;
		token = '0;
	end
	task automatic set_status(input logic [13:0] v);
		@(negedge clk);
		utmi_stat = v;
	endtask
	task automatic send_token(input logic [3:0] pid, input logic pok, input logic cok,
		input logic [6:0] ad, input logic [3:0] ep);
		@(negedge clk);
		token = {1'b1, pid, pok, cok, ad, ep};
		@(negedge clk);
		token = {1'b0, ~pid, ~pok, ~cok, ~ad, ~ep};
	endtask
endmodule

/* File: verification/tb_top.sv */
// Purpose: Self-checking bench for the interface manager register bank
// Assumes: Inputs change at the falling edge, one request at a time
// Notes: Transceiver side comes from uifc_phy_model
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk;
	logic rst;
	uifc_pkg::uifc_req_s req;
	uifc_pkg::uifc_resp_s resp;
	uifc_pkg::uifc_utmi_stat_s utmi_stat;
	uifc_pkg::uifc_utmi_ctrl_s utmi_ctrl;
	uifc_pkg::uifc_token_s token;
	logic token_pass;
	logic [4:0] token_endpoint;
	logic [3:0] port_flag;
	logic [7:0] mode_enables;
	int fail_count;
	int samples_checked;
	logic [31:0] rd;
	logic got;
	logic er;
	logic [7:0] ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
	logic [31:0] dflt [7] = '{32'h0, 32'h0, 32'h0, 32'h07, 32'h0, 32'h0, 32'h2};
	uifc_regs uut (.clk(clk), .rst(rst), .req(req), .resp(resp), .utmi_stat(utmi_stat),
		.utmi_ctrl(utmi_ctrl), .token(token), .token_pass(token_pass),
		.token_endpoint(token_endpoint), .port_flag(port_flag), .mode_enables(mode_enables));
	uifc_phy_model phy (.clk(clk), .utmi_stat(utmi_stat), .token(token));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] per, input logic [7:0] ad,
		input logic w32, input logic [31:0] wd);
		@(negedge clk);
		req = {1'b1, wr, per, ad, w32, wd};
		@(negedge clk);
		rd = resp.rdata;
		got = resp.valid;
		er = resp.error;
		req = {1'b0, ~wr, ~per, ~ad, ~w32, ~wd};
	endtask
	task automatic wr32(input logic [7:0] ad, input logic [31:0] wd);
		bus(1'b1, 8'h01, ad, 1'b1, wd);
		check({30'h0, got, er}, 32'h2);
	endtask
	task automatic rchk(input logic [7:0] ad, input logic [31:0] exp);
		bus(1'b0, 8'h01, ad, 1'b1, 32'h0);
		check({30'h0, got, er}, 32'h2);
		check(rd, exp);
	endtask
	task automatic chk_defaults();
		for (int i = 0; i < 7; i++) begin
			rchk(ofs[i], dflt[i]);
		end
	endtask
	task automatic end_test(input string name);
		$display("Test %s finished", name);
	endtask
	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		fail_count++;
		$display("ERROR at %0t: watchdog expired", $time);
		finish_test();
	end
	initial begin
		fail_count = 0;
		samples_checked = 0;
		rst = 1'b1;
		req = '0;
		repeat (16) @(negedge clk);
		rst = 1'b0;
		chk_defaults();
		end_test("reset values");
		wr32(8'h04, 32'hFFFF_FFFF);
		rchk(8'h04, 32'hF7);
		check({24'h0, mode_enables}, 32'hF7);
		wr32(8'h0C, 32'h0);
		check(32'(utmi_ctrl.opmode), 32'h0);
		wr32(8'h10, 32'hFFFF_FFFF);
		rchk(8'h10, 32'hDF);
		check(32'({utmi_ctrl.chrgvbus, utmi_ctrl.dischrgvbus, utmi_ctrl.dmpulldown,
			utmi_ctrl.dppulldown, utmi_ctrl.identification_pullup}), 32'h1F);
		wr32(8'h18, 32'h0000_000D);
		check(32'(utmi_ctrl.transmit_enable_low), 32'h0);
		phy.set_status(14'h2AA0);
		rchk(8'h14, 32'h15);
		rchk(8'h18, 32'h5D);
		end_test("control words");
		bus(1'b0, 8'h02, 8'h04, 1'b1, 32'h0);
		check(32'(got), 32'h0);
		bus(1'b1, 8'h01, 8'h04, 1'b0, 32'h0);
		check({30'h0, got, er}, 32'h3);
		rchk(8'h04, 32'hF7);
		bus(1'b0, 8'h01, 8'h44, 1'b1, 32'h0);
		check(32'(er), 32'h1);
		rchk(8'h00, 32'h0);
		wr32(8'h14, 32'hFFFF_FFFF);
		rchk(8'h14, 32'h15);
		end_test("refusals");
		wr32(8'h00, 32'hDEAD_BEEF);
		phy.set_status(14'h0);
		chk_defaults();
		end_test("soft reset");
		wr32(8'h04, 32'h1);
		phy.send_token(4'h9, 1'b1, 1'b1, 7'h00, 4'h3);
		check(32'(token_pass), 32'h1);
		wr32(8'h08, 32'h2A);
		rchk(8'h08, 32'h2A);
		wr32(8'h1C, 32'h40);
		phy.send_token(4'h9, 1'b1, 1'b1, 7'h00, 4'h3);
		check(32'(token_pass), 32'h0);
		phy.send_token(4'h9, 1'b1, 1'b0, 7'h2A, 4'h3);
		check(32'(token_pass), 32'h0);
		phy.send_token(4'h9, 1'b0, 1'b1, 7'h2A, 4'h3);
		check(32'(token_pass), 32'h0);
		rchk(8'h1C, 32'h0);
		phy.send_token(4'h9, 1'b1, 1'b1, 7'h2A, 4'hB);
		check(32'(token_pass), 32'h1);
		rchk(8'h1C, 32'h40);
		rchk(8'h30, 32'h1B);
		check(32'(token_endpoint), 32'h0B);
		wr32(8'h34, 32'h0000_0800);
		wr32(8'h24, 32'h0000_0040);
		wr32(8'h1C, 32'h40);
		check(32'(port_flag), 32'h0);
		phy.send_token(4'h9, 1'b1, 1'b1, 7'h2A, 4'hB);
		check(32'(token_endpoint), 32'h1B);
		check(32'(port_flag), 32'h1);
		phy.set_status(14'h0010);
		rchk(8'h1C, 32'h02);
		check(32'(port_flag), 32'h0);
		wr32(8'h20, 32'h40);
		phy.set_status(14'h0);
		phy.send_token(4'h9, 1'b1, 1'b1, 7'h2A, 4'hB);
		phy.set_status(14'h0010);
		rchk(8'h1C, 32'h42);
		wr32(8'h1C, 32'h40);
		rchk(8'h1C, 32'h02);
		end_test("tokens");
		finish_test();
	end
endmodule
